// ===== core/reg_access_engine.sv
// Control-byte decoder that serves register reads and writes over the process image.
`timescale 1ns/100ps
`default_nettype none
module reg_access_engine
    import reg_access_pkg::*;
(
    input  wire logic              i_core_clk,
    input  wire logic              i_reset,
    input  wire logic [CTRL_W-1:0] i_control_byte,
    input  wire logic [WORD_W-1:0] i_host_write_word,
    input  wire logic              i_power_cycle,
    output logic      [CTRL_W-1:0] o_status_byte,
    output logic      [WORD_W-1:0] o_terminal_reply_word,
    output logic                   o_write_protect,
    output logic      [WORD_W-1:0] o_feature_active
);
    access_state_t     state_reg;
    access_state_t     state_next;
    logic [CTRL_W-1:0] status_reg;
    logic [CTRL_W-1:0] status_next;
    logic [WORD_W-1:0] reply_reg;
    logic [WORD_W-1:0] reply_next;
    logic              protect_reg;
    logic              protect_next;
    logic [CTRL_W-1:0] served_reg;
    logic [CTRL_W-1:0] served_next;
    logic              req;
    logic              is_write;
    logic [REG_NUM_W-1:0] reg_num;
    logic              new_req;
    logic              wr_en;
    logic [WORD_W-1:0] rd_data;

    // Both flag bits sit above the register number field, or the decode overlaps.
    if (BIT_WRITE < REG_NUM_W || BIT_REG_ACCESS <= BIT_WRITE
            || BIT_REG_ACCESS >= CTRL_W) begin : g_bad_layout
        $error("Control byte layout cannot hold the flags and the register number.");
    end
    // The register number must reach every entry of the store and no further.
    if (REG_COUNT != (1 << REG_NUM_W)) begin : g_bad_count
        $error("Register count does not match the register number field.");
    end

    assign req      = i_control_byte[BIT_REG_ACCESS];
    assign is_write = i_control_byte[BIT_WRITE];
    assign reg_num  = i_control_byte[REG_NUM_W-1:0];
    // A request is served once; a changed control byte counts as a new one.
    assign new_req  = req && (state_reg == ST_IDLE || i_control_byte != served_reg);
    assign wr_en    = new_req && is_write && (!protect_reg || reg_num == OFS_WP_KEY);

    reg_store #(
        .DEPTH (REG_COUNT)
    ) u_store (
        .i_core_clk       (i_core_clk),
        .i_reset          (i_reset),
        .i_wr_en          (wr_en),
        .i_addr           (reg_num),
        .i_wr_data        (i_host_write_word),
        .i_apply          (i_power_cycle),
        .o_rd_data        (rd_data),
        .o_feature_active (o_feature_active)
    );

    always_comb begin
        state_next   = state_reg;
        status_next  = status_reg;
        reply_next   = reply_reg;
        protect_next = protect_reg;
        served_next  = served_reg;
        if (!req) begin
            state_next  = ST_IDLE;
            status_next = i_control_byte;
        end else if (new_req) begin
            state_next  = ST_DONE;
            served_next = i_control_byte;
            if (is_write) begin
                status_next = i_control_byte & ~(8'h01 << BIT_WRITE);
                if (reg_num == OFS_WP_KEY) begin
                    protect_next = (i_host_write_word != WP_KEY_VALUE);
                end
            end else begin
                status_next = i_control_byte;
                reply_next  = rd_data;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            state_reg   <= ST_IDLE;
            status_reg  <= RST_STATUS;
            reply_reg   <= RST_WORD;
            protect_reg <= 1'b1;
            served_reg  <= RST_STATUS;
        end else begin
            state_reg   <= state_next;
            status_reg  <= status_next;
            reply_reg   <= reply_next;
            protect_reg <= protect_next;
            served_reg  <= served_next;
        end
    end

    assign o_status_byte         = status_reg;
    assign o_terminal_reply_word = reply_reg;
    assign o_write_protect       = protect_reg;

    sequence s_key_write;
        new_req && is_write && reg_num == OFS_WP_KEY;
    endsequence

    // A request whose control byte still stands one cycle later, so the read port
    // shows the same register again and a landed or refused write becomes visible.
    sequence s_then_held(ev);
        ev ##1 (i_control_byte == $past(i_control_byte));
    endsequence

    a_read_ack_echo: assert property (@(posedge i_core_clk) disable iff (i_reset)
        new_req && !is_write |=> o_status_byte == $past(i_control_byte))
        else $error("Read acknowledge differs from control byte.");

    a_read_data_word: assert property (@(posedge i_core_clk) disable iff (i_reset)
        new_req && !is_write |=> o_terminal_reply_word == $past(rd_data))
        else $error("Read reply word is not the register value.");

    a_write_ack_bit: assert property (@(posedge i_core_clk) disable iff (i_reset)
        new_req && is_write |=> o_status_byte == ($past(i_control_byte) & 8'hbf))
        else $error("Write acknowledge is wrong.");

    a_key_unlock_now: assert property (@(posedge i_core_clk) disable iff (i_reset)
        s_key_write ##0 (i_host_write_word == WP_KEY_VALUE) |=> !o_write_protect)
        else $error("Key did not unlock.");

    a_key_relock_now: assert property (@(posedge i_core_clk) disable iff (i_reset)
        s_key_write ##0 (i_host_write_word != WP_KEY_VALUE) |=> o_write_protect)
        else $error("Non-key write did not relock.");

    // A refused write is watched through the store itself, not through the gate.
    a_protect_blocks: assert property (@(posedge i_core_clk) disable iff (i_reset)
        s_then_held(new_req && is_write && o_write_protect && reg_num != OFS_WP_KEY)
            |-> $stable(rd_data))
        else $error("Protected register was written.");

    // A read must leave the addressed register as it was.
    a_read_no_store: assert property (@(posedge i_core_clk) disable iff (i_reset)
        s_then_held(req && !is_write) |-> $stable(rd_data))
        else $error("Read request stored data.");

    a_feature_waits: assert property (@(posedge i_core_clk) disable iff (i_reset)
        !i_power_cycle |=> $stable(o_feature_active))
        else $error("Feature changed without restart.");

    a_idle_no_reply: assert property (@(posedge i_core_clk) disable iff (i_reset)
        !req |=> $stable(o_terminal_reply_word) && !o_status_byte[BIT_REG_ACCESS])
        else $error("Reply changed outside register access.");

    // The status byte keeps following the host while register access is off.
    a_idle_mirror_byte: assert property (@(posedge i_core_clk) disable iff (i_reset)
        !req |=> o_status_byte == $past(i_control_byte))
        else $error("Status byte does not mirror the idle control byte.");

    // A request already served must not disturb its acknowledgement.
    a_ack_holds_steady: assert property (@(posedge i_core_clk) disable iff (i_reset)
        req && !new_req |=> $stable(o_status_byte) && $stable(o_terminal_reply_word))
        else $error("Acknowledge changed while the request stood.");

    // The reply after a write is invalid for the host, so it simply keeps its old value.
    a_write_keeps_reply: assert property (@(posedge i_core_clk) disable iff (i_reset)
        new_req && is_write |=> $stable(o_terminal_reply_word))
        else $error("Reply word changed on a write.");

    // Refused writes are still acknowledged, so the host is never left waiting.
    a_refused_still_ack: assert property (@(posedge i_core_clk) disable iff (i_reset)
        new_req && is_write && o_write_protect
            |=> o_status_byte[BIT_REG_ACCESS] && !o_status_byte[BIT_WRITE])
        else $error("Refused write was not acknowledged.");

    a_open_write_lands: assert property (@(posedge i_core_clk) disable iff (i_reset)
        s_then_held(new_req && is_write && !o_write_protect)
            |-> rd_data == $past(i_host_write_word))
        else $error("Unprotected write did not reach the register.");

    // The key register stays writable, otherwise protection could never be lifted.
    a_key_write_lands: assert property (@(posedge i_core_clk) disable iff (i_reset)
        s_then_held(new_req && is_write && reg_num == OFS_WP_KEY)
            |-> rd_data == $past(i_host_write_word))
        else $error("Key register write did not reach the register.");

    a_protect_key_only: assert property (@(posedge i_core_clk) disable iff (i_reset)
        !(new_req && is_write && reg_num == OFS_WP_KEY) |=> $stable(o_write_protect))
        else $error("Protection changed without a key register write.");

    // A restart copies the stored feature word, including writes made before it.
    a_feature_from_store: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_power_cycle && reg_num == OFS_FEATURE |=> o_feature_active == $past(rd_data))
        else $error("Restart did not load the stored feature word.");
endmodule : reg_access_engine
`default_nettype wire

// ===== core/reg_store.sv
// Register array of the terminal, with an active copy of the feature word taken on restart.
`timescale 1ns/100ps
`default_nettype none
module reg_store
    import reg_access_pkg::*;
#(
    parameter int DEPTH = REG_COUNT
) (
    input  wire logic                 i_core_clk,
    input  wire logic                 i_reset,
    input  wire logic                 i_wr_en,
    input  wire logic [REG_NUM_W-1:0] i_addr,
    input  wire logic [WORD_W-1:0]    i_wr_data,
    input  wire logic                 i_apply,
    output logic      [WORD_W-1:0]    o_rd_data,
    output logic      [WORD_W-1:0]    o_feature_active
);
    // The read port decodes every register number, so the array must cover them all.
    if (DEPTH != (1 << REG_NUM_W)) begin : g_bad_depth
        $error("reg_store depth must equal the register number range");
    end

    logic [WORD_W-1:0] mem_reg [DEPTH];
    logic [WORD_W-1:0] mem_next [DEPTH];
    logic [WORD_W-1:0] feature_reg;
    logic [WORD_W-1:0] feature_next;

    // Stored values only steer the terminal after a restart, modelled by i_apply.
    always_comb begin
        mem_next = mem_reg;
        feature_next = feature_reg;
        if (i_wr_en) begin
            mem_next[i_addr] = i_wr_data;
        end
        if (i_apply) begin
            feature_next = mem_reg[OFS_FEATURE];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= RST_WORD;
            end
            feature_reg <= RST_WORD;
        end else begin
            mem_reg     <= mem_next;
            feature_reg <= feature_next;
        end
    end

    assign o_rd_data        = mem_reg[i_addr];
    assign o_feature_active = feature_reg;
endmodule : reg_store
`default_nettype wire

// ===== inc/reg_access_pkg.sv
// Package of constants for the terminal register access engine.
package reg_access_pkg;
    localparam int          CTRL_W          = 8;
    localparam int          WORD_W          = 16;
    localparam int          REG_NUM_W       = 6;
    localparam int          REG_COUNT       = 64;
    localparam int          BIT_REG_ACCESS  = 7;
    localparam int          BIT_WRITE       = 6;
    localparam logic [5:0]  OFS_WP_KEY      = 6'h1f;
    localparam logic [5:0]  OFS_FEATURE     = 6'h20;
    localparam logic [15:0] WP_KEY_VALUE    = 16'h1235;
    localparam logic [15:0] RST_WORD        = 16'h0000;
    localparam logic [7:0]  RST_STATUS      = 8'h00;
    typedef enum logic [0:0] {ST_IDLE, ST_DONE} access_state_t;
endpackage : reg_access_pkg

// ===== verif/host_model.sv
// Host model that places register requests in the process image and waits for the receipt.
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input  wire logic        i_core_clk,
    input  wire logic [7:0]  i_status_byte,
    input  wire logic [15:0] i_terminal_reply_word,
    output logic      [7:0]  o_control_byte,
    output logic      [15:0] o_host_write_word
);
    initial begin
        o_control_byte    = 8'h00;
        o_host_write_word = 16'h0000;
    end

    task automatic request(input logic [7:0] ctrl, input logic [15:0] word,
                           output logic [7:0] stat, output logic [15:0] reply);
        logic [7:0] ack;
        ack = ctrl[6] ? (ctrl & 8'hbf) : ctrl;
        // access bit dropped for one cycle between requests.
        @(posedge i_core_clk);
        #5;
        o_control_byte = 8'h00;
        @(posedge i_core_clk);
        #5;
        o_control_byte = ctrl;
        // write word on writes, a changing pattern on reads.
        o_host_write_word = ctrl[6] ? word : ~o_host_write_word;
        stat = 8'h00;
        // request held until the receipt shows, with a bounded wait.
        for (int n = 0; n < 8 && stat !== ack; n++) begin
            @(posedge i_core_clk);
            #5;
            stat = i_status_byte;
        end
        // reply after a write is handed back but never judged.
        reply = i_terminal_reply_word;
    endtask : request
endmodule : host_model
`default_nettype wire

// ===== verif/reg_access_engine_tb.sv
// Self-checking bench for the register access engine driven by the host model.
`timescale 1ns/100ps
`default_nettype none
module reg_access_engine_tb;
    import reg_access_pkg::*;
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [15:0] word;
        logic [7:0]  stat;
        logic [15:0] reply;
        logic        is_read;
        logic        prot;
    } row_t;
    logic        i_core_clk    = 1'b0;
    logic        i_reset       = 1'b1;
    logic        i_power_cycle = 1'b0;
    logic [7:0]  control_byte, status_byte, stat;
    logic [15:0] host_write_word, reply_word, feature_active, reply;
    logic        write_protect;
    int          mismatches = 0;
    int          n_compared = 0;
    // Refused writes while protected, unlock, both register-number ends, relock.
    row_t        rows [17] = '{
        '{8'h9f, 16'h0000, 8'h9f, 16'h0000, 1'b1, 1'b1},
        '{8'he0, 16'h0002, 8'ha0, 16'h0000, 1'b0, 1'b1},
        '{8'ha0, 16'h0000, 8'ha0, 16'h0000, 1'b1, 1'b1},
        '{8'hdf, 16'h1235, 8'h9f, 16'h0000, 1'b0, 1'b0},
        '{8'h9f, 16'h0000, 8'h9f, 16'h1235, 1'b1, 1'b0},
        '{8'he0, 16'h0002, 8'ha0, 16'h0000, 1'b0, 1'b0},
        '{8'ha0, 16'h0000, 8'ha0, 16'h0002, 1'b1, 1'b0},
        '{8'hc0, 16'ha5c3, 8'h80, 16'h0000, 1'b0, 1'b0},
        '{8'h80, 16'h0000, 8'h80, 16'ha5c3, 1'b1, 1'b0},
        '{8'hff, 16'h3c5a, 8'hbf, 16'h0000, 1'b0, 1'b0},
        '{8'hbf, 16'h0000, 8'hbf, 16'h3c5a, 1'b1, 1'b0},
        '{8'hdf, 16'h0000, 8'h9f, 16'h0000, 1'b0, 1'b1},
        '{8'h9f, 16'h0000, 8'h9f, 16'h0000, 1'b1, 1'b1},
        '{8'hdf, 16'h1235, 8'h9f, 16'h0000, 1'b0, 1'b0},
        '{8'hdf, 16'h4321, 8'h9f, 16'h0000, 1'b0, 1'b1},
        '{8'he0, 16'h7777, 8'ha0, 16'h0000, 1'b0, 1'b1},
        '{8'ha0, 16'h0000, 8'ha0, 16'h0002, 1'b1, 1'b1}};

    always #25 i_core_clk = ~i_core_clk;

    reg_access_engine DUT (
        .i_core_clk           (i_core_clk),
        .i_reset              (i_reset),
        .i_control_byte       (control_byte),
        .i_host_write_word    (host_write_word),
        .i_power_cycle        (i_power_cycle),
        .o_status_byte        (status_byte),
        .o_terminal_reply_word(reply_word),
        .o_write_protect      (write_protect),
        .o_feature_active     (feature_active)
    );
    host_model host (
        .i_core_clk           (i_core_clk),
        .i_status_byte        (status_byte),
        .i_terminal_reply_word(reply_word),
        .o_control_byte       (control_byte),
        .o_host_write_word    (host_write_word)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    // Whole run needs under a hundred cycles, so 4000 means a hang.
    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end

    initial begin
        repeat (3) @(posedge i_core_clk);
        #5 i_reset = 1'b0;
        foreach (rows[k]) begin
            host.request(rows[k].ctrl, rows[k].word, stat, reply);
            check(16'(stat), 16'(rows[k].stat));
            if (rows[k].is_read) check(reply, rows[k].reply);
            check(16'(write_protect), 16'(rows[k].prot));
        end
        $display("Row tests done");
        check(feature_active, 16'h0000);
        @(posedge i_core_clk);
        #5 i_power_cycle = 1'b1;
        @(posedge i_core_clk);
        #5 i_power_cycle = 1'b0;
        @(posedge i_core_clk);
        #5 check(feature_active, 16'h0002);
        $display("Restart test done");
        host.request(8'h5f, 16'h1235, stat, reply);
        check(16'(stat), 16'h005f);
        check(16'(write_protect), 16'h0001);
        $display("Access bit test done");
        i_reset = 1'b1;
        repeat (3) @(posedge i_core_clk);
        #5 check(16'(status_byte), 16'(RST_STATUS));
        check(reply_word, RST_WORD);
        check(16'(write_protect), 16'h0001);
        check(feature_active, RST_WORD);
        i_reset = 1'b0;
        host.request(8'ha0, 16'h0000, stat, reply);
        check(16'(stat), 16'h00a0);
        check(reply, 16'h0000);
        $display("Reset test done");
        report_and_stop();
    end
endmodule : reg_access_engine_tb
`default_nettype wire
